/* design/tppc_pkg.sv */
// tppc_pkg: constants, state types and carriers of the test port block
// assumes: shared by the test port top, its controller leaf and the testbench files
package tppc_pkg;

   // ************************************************
   // sizes
   // ************************************************
   localparam int IO_PINS   = 8;
   localparam int BSR_LEN   = 3 * IO_PINS;
   localparam int IR_W      = 8;
   localparam int ID_W      = 32;
   localparam int CFG_W     = 32;
   localparam int CFG_WORDS = 16;
   localparam int CFG_AW    = 4;

   // ************************************************
   // instruction codes
   // ************************************************
   localparam logic [IR_W-1:0] IR_EXTEST   = 8'h00;
   localparam logic [IR_W-1:0] IR_IDCODE   = 8'h01;
   localparam logic [IR_W-1:0] IR_INTEST   = 8'h02;
   localparam logic [IR_W-1:0] IR_PRELOAD  = 8'h03;
   localparam logic [IR_W-1:0] IR_CLAMP    = 8'hFA;
   localparam logic [IR_W-1:0] IR_HIGHZ    = 8'hFC;
   localparam logic [IR_W-1:0] IR_USERCODE = 8'hFD;
   localparam logic [IR_W-1:0] IR_BYPASS   = 8'hFF;
   localparam logic [IR_W-1:0] IR_CAPTURE  = 8'h01;

   // ************************************************
   // reset values and configuration layout
   // ************************************************
   // identification word: value arbitrary, bit 0 set as required
   localparam logic [ID_W-1:0]   ID_WORD_DEFAULT = 32'h0000_1001;
   localparam logic [CFG_AW-1:0] CFG_USER_ADDR   = 4'h0;
   localparam logic [CFG_AW-1:0] CFG_KEEP_ADDR   = 4'h1;
   localparam logic [CFG_AW-1:0] CFG_LAST_ADDR   = 4'hF;
   localparam int                TCK_MAX_MHZ     = 66;

   // ************************************************
   // types
   // ************************************************
   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR,
      UPD_DR, SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
   } tppc_tap_t;

   typedef enum logic [2:0] {
      M_NORMAL, M_EXTEST, M_INTEST, M_HIGHZ, M_CLAMP
   } tppc_mode_t;

   typedef enum logic [1:0] {
      PH_QUIET, PH_LOAD, PH_FETCH, PH_RUN
   } tppc_phase_t;

   // one boundary cell triple per pin
   typedef struct packed {
      logic [IO_PINS-1:0] din;
      logic [IO_PINS-1:0] dout;
      logic [IO_PINS-1:0] doe;
   } tppc_cells_t;

   // pad drive group
   typedef struct packed {
      logic [IO_PINS-1:0] dout;
      logic [IO_PINS-1:0] oe_n;
      logic [IO_PINS-1:0] pull;
   } tppc_pads_t;

endpackage

/* design/tppc_tap_fsm.sv */
// tppc_tap_fsm: sixteen-state test access controller
// assumes: clocked by the test clock, reset synchronous on that clock
`timescale 1ns/1ps
module tppc_tap_fsm (
   input  wire logic             tck,     // test clock
   input  wire logic             rst_n,   // sync reset, test clock domain
   input  wire logic             tms,     // mode select
   output tppc_pkg::tppc_tap_t   state    // controller state
);
   import tppc_pkg::*;

   tppc_tap_t next_state;

   always_comb begin
      case (state)
         TAP_RESET: next_state = tms ? TAP_RESET : TAP_IDLE;
         TAP_IDLE:  next_state = tms ? SEL_DR : TAP_IDLE;
         SEL_DR:    next_state = tms ? SEL_IR : CAP_DR;
         CAP_DR:    next_state = tms ? EX1_DR : SHF_DR;
         SHF_DR:    next_state = tms ? EX1_DR : SHF_DR;
         EX1_DR:    next_state = tms ? UPD_DR : PAU_DR;
         PAU_DR:    next_state = tms ? EX2_DR : PAU_DR;
         EX2_DR:    next_state = tms ? UPD_DR : SHF_DR;
         UPD_DR:    next_state = tms ? SEL_DR : TAP_IDLE;
         SEL_IR:    next_state = tms ? TAP_RESET : CAP_IR;
         CAP_IR:    next_state = tms ? EX1_IR : SHF_IR;
         SHF_IR:    next_state = tms ? EX1_IR : SHF_IR;
         EX1_IR:    next_state = tms ? UPD_IR : PAU_IR;
         PAU_IR:    next_state = tms ? EX2_IR : PAU_IR;
         EX2_IR:    next_state = tms ? UPD_IR : SHF_IR;
         UPD_IR:    next_state = tms ? SEL_DR : TAP_IDLE;
         default:   next_state = TAP_RESET;
      endcase
   end

   always_ff @(posedge tck) begin
      if (!rst_n) begin
         state <= TAP_RESET;
      end else begin
         state <= next_state;
      end
   end

endmodule

/* design/tppc_cfg_store.sv */
// tppc_cfg_store: volatile configuration cells, registered read port
// assumes: one writer and one reader on the same clock
`timescale 1ns/1ps
module tppc_cfg_store #(
   parameter int W     = 32,
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   input  wire logic          clk,       // core clock
   input  wire logic          wr_en,     // write strobe
   input  wire logic [AW-1:0] wr_addr,   // write address
   input  wire logic [W-1:0]  wr_data,   // write data
   input  wire logic [AW-1:0] rd_addr,   // read address
   output logic [W-1:0]       rd_data    // read data, one cycle late
);

   logic [W-1:0] cells [DEPTH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         cells[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      rd_data <= cells[rd_addr];
   end

endmodule

/* design/tppc_top.sv */
// tppc_top: test access port with power-up control of pins and fabric
// assumes: nonvolatile store answers one cycle after a read on ref_clk;
// tck is the host's test clock, may stop between scans
`timescale 1ns/1ps

// How it works
// RQ1 - extest drives boundary cell contents out onto the output pins
// RQ2 - preload samples macrocell values into the cells, pins untouched
// RQ3 - all-ones code puts one-bit bypass between serial in and out
// RQ4 - intest feeds boundary cell values to internal logic inputs
// RQ5 - idcode shifts fixed id word, usercode shifts programmed user word
// RQ6 - highz floats every user output while it is the instruction
// RQ7 - clamp holds pins at captured levels with bypass selected
// RQ8 - test logic works with test clock up to 66 MHz
// RQ9 - before supply is safe, test port off and outputs off, pulled up
// RQ10 - once supply safe, registers initialise and device runs at once
// RQ11 - configuration copied from nonvolatile store before pins configure
// RQ12 - pins, inputs, clocks and fabric stay off until power-up done
// RQ13 - erased part keeps outputs off and pulled up, test port enabled
// RQ14 - programmed part runs pins as configured, test port enabled
// RQ15 - host brings the bitstream as standard configuration commands; no such commands here, configuration comes only from the store
// RQ16 - standard controller, instruction loads on update, id after reset
module tppc_top (
   input  wire logic                      ref_clk,          // core clock
   input  wire logic                      reset_n,          // sync reset
   input  wire logic                      core_supply_good, // supply safe pin
   input  wire logic                      nv_programmed,    // store holds pattern
   output logic                           nv_rd_en,         // store read strobe
   output logic [tppc_pkg::CFG_AW-1:0]    nv_addr,          // store address
   input  wire logic [tppc_pkg::CFG_W-1:0] nv_data,         // store data
   input  wire logic                      tck,              // test clock
   input  wire logic                      tms,              // test mode select
   input  wire logic                      tdi,              // serial test in
   output logic                           tdo,              // serial test out
   output logic                           tdo_oe_n,         // tdo enable, low on
   input  wire logic [tppc_pkg::IO_PINS-1:0] pad_in,        // pin levels
   output tppc_pkg::tppc_pads_t           pads,             // pin drive
   input  wire logic [tppc_pkg::IO_PINS-1:0] core_out,      // macrocell outputs
   input  wire logic [tppc_pkg::IO_PINS-1:0] core_oe,       // macrocell enables
   output logic [tppc_pkg::IO_PINS-1:0]   core_in,          // fabric inputs
   output logic                           fabric_enable,    // fabric and clocks on
   output logic                           port_enabled      // test port on
);
   import tppc_pkg::*;

   // ************************************************
   // core domain: supply and power-up phase
   // ************************************************
   logic                supply_s1;
   logic                supply_ok;
   tppc_phase_t         phase;
   logic [CFG_AW-1:0]   ld_addr;
   logic                ld_wr;
   logic [CFG_AW-1:0]   ld_wr_addr;
   logic [1:0]          fetch_cnt;
   logic [CFG_AW-1:0]   rd_addr;
   logic [CFG_W-1:0]    rd_data;
   logic                programmed;
   logic [ID_W-1:0]     usercode;
   logic [IO_PINS-1:0]  keep_mask;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         {supply_ok, supply_s1} <= 2'b00;
      end else begin
         {supply_ok, supply_s1} <= {supply_s1, core_supply_good};
      end
   end

   // RQ9 quiet until safe
   // RQ10 run after copy and fetch of user word and keep mask
   always_ff @(posedge ref_clk) begin
      if (!reset_n || !supply_ok) begin
         phase <= PH_QUIET;
      end else begin
         case (phase)
            PH_QUIET: phase <= PH_LOAD;
            PH_LOAD:  if (ld_wr && ld_wr_addr == CFG_LAST_ADDR) phase <= PH_FETCH;
            PH_FETCH: if (fetch_cnt == 2'd2) phase <= PH_RUN;
            PH_RUN:   phase <= PH_RUN;
            default:  phase <= PH_QUIET;
         endcase
      end
   end

   // RQ11 copy store to cells
   always_ff @(posedge ref_clk) begin
      if (!reset_n || phase != PH_LOAD) begin
         ld_addr    <= '0;
         nv_rd_en   <= 1'b0;
         ld_wr      <= 1'b0;
         ld_wr_addr <= '0;
      end else begin
         nv_rd_en   <= (ld_addr != CFG_LAST_ADDR);
         if (nv_rd_en && ld_addr != CFG_LAST_ADDR) begin
            ld_addr <= ld_addr + 1'b1;
         end
         ld_wr      <= nv_rd_en;
         ld_wr_addr <= ld_addr;
      end
   end

   assign nv_addr = ld_addr;

   tppc_cfg_store #(
      .W     (CFG_W),
      .DEPTH (CFG_WORDS),
      .AW    (CFG_AW)
   ) u_cfg (
      .clk     (ref_clk),
      .wr_en   (ld_wr && phase == PH_LOAD),
      .wr_addr (ld_wr_addr),
      .wr_data (nv_data),
      .rd_addr (rd_addr),
      .rd_data (rd_data)
   );

   assign rd_addr = (fetch_cnt == 2'd0) ? CFG_USER_ADDR : CFG_KEEP_ADDR;

   // fetch user word and pin keeper mask from the cells
   always_ff @(posedge ref_clk) begin
      if (!reset_n || phase != PH_FETCH) begin
         fetch_cnt <= 2'd0;
      end else if (fetch_cnt != 2'd2) begin
         fetch_cnt <= fetch_cnt + 2'd1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n || phase == PH_QUIET) begin
         usercode   <= '0;
         keep_mask  <= '1;
         programmed <= 1'b0;
      end else if (phase == PH_FETCH) begin
         if (fetch_cnt == 2'd1) usercode <= rd_data;
         if (fetch_cnt == 2'd2) keep_mask <= rd_data[IO_PINS-1:0];
         programmed <= nv_programmed;
      end
   end

   // RQ13 port on when erased
   // RQ14 port on when programmed
   always_ff @(posedge ref_clk) begin
      port_enabled  <= reset_n && (phase == PH_RUN);
      fabric_enable <= reset_n && (phase == PH_RUN) && programmed;
   end

   // ************************************************
   // test clock domain: controller and registers
   // ************************************************
   logic                en_t1;
   logic                tck_rst_n;
   tppc_tap_t           tap;
   logic [IR_W-1:0]     ir;
   logic [IR_W-1:0]     ir_shift;
   logic                bypass;
   logic [ID_W-1:0]     id_shift;
   logic [BSR_LEN-1:0]  bsr_shift;
   tppc_cells_t         upd;
   logic [BSR_LEN-1:0]  cap_t1;
   logic [BSR_LEN-1:0]  cap_t2;
   tppc_mode_t          mode;
   logic                sel_bsr;
   logic                sel_id;
   logic                pub_tgl;
   logic                next_tdo;

   // port enable into the test domain, used as its reset
   always_ff @(posedge tck) begin
      {tck_rst_n, en_t1} <= {en_t1, port_enabled};
   end

   // RQ8 sampled pins each tck
   always_ff @(posedge tck) begin
      {cap_t2, cap_t1} <= {cap_t1, pad_in, core_out, core_oe};
   end

   // RQ16 standard controller
   tppc_tap_fsm u_tap (
      .tck   (tck),
      .rst_n (tck_rst_n),
      .tms   (tms),
      .state (tap)
   );

   // RQ16 load on update only
   always_ff @(posedge tck) begin
      if (!tck_rst_n || tap == TAP_RESET) begin
         ir <= IR_IDCODE;
      end else if (tap == UPD_IR) begin
         ir <= ir_shift;
      end
   end

   always_ff @(posedge tck) begin
      if (!tck_rst_n || tap == CAP_IR) begin
         ir_shift <= IR_CAPTURE;
      end else if (tap == SHF_IR) begin
         ir_shift <= {tdi, ir_shift[IR_W-1:1]};
      end
   end

   always_comb begin
      sel_bsr = 1'b0;
      sel_id  = 1'b0;
      mode    = M_NORMAL;
      case (ir)
         // RQ1 extest decode
         IR_EXTEST:   begin sel_bsr = 1'b1; mode = M_EXTEST; end
         // RQ2 preload keeps pins
         IR_PRELOAD:  sel_bsr = 1'b1;
         // RQ4 intest decode
         IR_INTEST:   begin sel_bsr = 1'b1; mode = M_INTEST; end
         // RQ5 id and user words
         IR_IDCODE, IR_USERCODE: sel_id = 1'b1;
         // RQ6 highz decode
         IR_HIGHZ:    mode = M_HIGHZ;
         // RQ7 clamp with bypass
         IR_CLAMP:    mode = M_CLAMP;
         default:     mode = M_NORMAL;
      endcase
   end

   // RQ3 one-bit bypass
   always_ff @(posedge tck) begin
      if (!tck_rst_n || tap == CAP_DR) begin
         bypass <= 1'b0;
      end else if (tap == SHF_DR) begin
         bypass <= tdi;
      end
   end

   // RQ5 id or user word shift
   always_ff @(posedge tck) begin
      if (!tck_rst_n) begin
         id_shift <= '0;
      end else if (tap == CAP_DR) begin
         id_shift <= (ir == IR_USERCODE) ? usercode : ID_WORD_DEFAULT;
      end else if (tap == SHF_DR) begin
         id_shift <= {tdi, id_shift[ID_W-1:1]};
      end
   end

   // RQ2 capture macrocell values
   always_ff @(posedge tck) begin
      if (!tck_rst_n) begin
         bsr_shift <= '0;
      end else if (tap == CAP_DR && sel_bsr) begin
         bsr_shift <= cap_t2;
      end else if (tap == SHF_DR && sel_bsr) begin
         bsr_shift <= {tdi, bsr_shift[BSR_LEN-1:1]};
      end
   end

   always_ff @(posedge tck) begin
      if (!tck_rst_n) begin
         upd <= '0;
      end else if (tap == UPD_DR && sel_bsr) begin
         upd <= bsr_shift;
      end
   end

   // announce new instruction or cell contents to the core side
   always_ff @(posedge tck) begin
      if (!tck_rst_n) begin
         pub_tgl <= 1'b0;
      end else if (tap == UPD_IR || tap == UPD_DR || (tap == TAP_RESET && ir != IR_IDCODE)) begin
         pub_tgl <= ~pub_tgl;
      end
   end

   always_comb begin
      if (tap == SHF_IR) next_tdo = ir_shift[0];
      else if (sel_bsr) next_tdo = bsr_shift[0];
      else if (sel_id) next_tdo = id_shift[0];
      else next_tdo = bypass;
   end

   // serial out changes on the falling edge
   always_ff @(negedge tck) begin
      if (!tck_rst_n) begin
         tdo      <= 1'b0;
         tdo_oe_n <= 1'b1;
      end else begin
         tdo      <= next_tdo;
         tdo_oe_n <= !(tap == SHF_DR || tap == SHF_IR);
      end
   end

   // ************************************************
   // crossing back: toggle, then take mode and cells
   // ************************************************
   logic          pub_r1;
   logic          pub_r2;
   logic          pub_r3;
   tppc_mode_t    mode_r;
   tppc_cells_t   cells_r;
   logic [IO_PINS-1:0] pin_s1;
   logic [IO_PINS-1:0] pin_s2;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         {pub_r3, pub_r2, pub_r1} <= 3'b000;
      end else begin
         {pub_r3, pub_r2, pub_r1} <= {pub_r2, pub_r1, pub_tgl};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n || phase != PH_RUN) begin
         mode_r  <= M_NORMAL;
         cells_r <= '0;
      end else if (pub_r2 != pub_r3) begin
         mode_r  <= mode;
         cells_r <= upd;
      end
   end

   always_ff @(posedge ref_clk) begin
      {pin_s2, pin_s1} <= {pin_s1, pad_in};
   end

   // ************************************************
   // pin and fabric drive, one slice per pin
   // ************************************************
   genvar gi;
   generate
      for (gi = 0; gi < IO_PINS; gi++) begin : g_pin
         // RQ12 all off until run
         always_ff @(posedge ref_clk) begin
            pads.pull[gi] <= !reset_n || phase != PH_RUN || keep_mask[gi] || !programmed;
            if (!reset_n || phase != PH_RUN) begin
               pads.dout[gi] <= 1'b0;
               pads.oe_n[gi] <= 1'b1;
            end else begin
               case (mode_r)
                  // RQ1 cells onto pins
                  // RQ7 hold captured levels
                  M_EXTEST, M_CLAMP: begin
                     pads.dout[gi] <= cells_r.dout[gi];
                     pads.oe_n[gi] <= ~cells_r.doe[gi];
                  end
                  // RQ6 all outputs floated
                  M_HIGHZ: begin
                     pads.dout[gi] <= 1'b0;
                     pads.oe_n[gi] <= 1'b1;
                  end
                  default: begin
                     // RQ13 erased stays off
                     // RQ14 programmed as configured
                     pads.dout[gi] <= programmed && core_out[gi];
                     pads.oe_n[gi] <= !(programmed && core_oe[gi]);
                  end
               endcase
            end
         end

         // RQ4 cells into fabric
         always_ff @(posedge ref_clk) begin
            if (!reset_n || phase != PH_RUN) begin
               core_in[gi] <= 1'b0;
            end else begin
               core_in[gi] <= (mode_r == M_INTEST) ? cells_r.din[gi] : programmed && pin_s2[gi];
            end
         end
      end
   endgenerate

endmodule

/* tb/tppc_host.sv */
// tppc_host: boundary-scan host driving the serial test port
// assumes: test clock stands low between scans, 12 ns period
`timescale 1ns/1ps
module tppc_host (
   output logic      tck, // test clock
   output logic      tms, // mode select
   output logic      tdi, // serial data to port
   input  wire logic tdo  // serial data from port
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // one test clock, 12 ns period
   task automatic pulse(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #5.5 q = tdo;
      #0.5 tck = 1'b1;
      #6 tck = 1'b0;
   endtask

   // five ones reach reset, then idle
   task automatic tap_reset();
      logic b;
      repeat (5) pulse(1'b1, ~tdi, b);
      pulse(1'b0, ~tdi, b);
   endtask

   // standard walk from idle, lsb first
   task automatic scan(input logic ir, input int n, input logic [31:0] d,
                       output logic [31:0] q);
      logic b;
      q = '0;
      #3.7;
      pulse(1'b1, ~tdi, b);
      if (ir) pulse(1'b1, ~tdi, b);
      pulse(1'b0, ~tdi, b);
      pulse(1'b0, ~tdi, b);
      for (int i = 0; i < n; i++) begin
         pulse(i == n - 1, d[i], b);
         q[i] = b;
      end
      pulse(1'b1, ~tdi, b);
      pulse(1'b0, ~tdi, b);
      tdi = ~tdi;
   endtask
endmodule

/* tb/tppc_chk.sv */
// tppc_chk: assertions on the ports of the test port top
// assumes: bound to tppc_top, two unrelated clocks
`timescale 1ns/1ps
module tppc_chk (
   input wire logic                      ref_clk,          // core clock
   input wire logic                      reset_n,          // sync reset
   input wire logic                      core_supply_good, // supply safe
   input wire logic                      nv_programmed,    // pattern held
   input wire logic                      nv_rd_en,         // store read
   input wire logic [tppc_pkg::CFG_AW-1:0] nv_addr,        // store address
   input wire logic                      tck,              // test clock
   input wire logic                      tdo_oe_n,         // tdo enable
   input wire tppc_pkg::tppc_pads_t      pads,             // pin drive
   input wire logic [tppc_pkg::IO_PINS-1:0] core_in,       // fabric inputs
   input wire logic                      fabric_enable,    // fabric on
   input wire logic                      port_enabled      // port on
);
   import tppc_pkg::*;

   quiet_pins_a:
   assert property (@(posedge ref_clk) disable iff (!reset_n) (!port_enabled)[*8]
      |-> (&pads.oe_n && &pads.pull && core_in == '0 && !fabric_enable))
      else $error("outputs active while port off");
   store_order_a:
   assert property (@(posedge ref_clk) disable iff (!reset_n)
      nv_rd_en && $past(nv_rd_en) |-> nv_addr == $past(nv_addr) + 4'h1)
      else $error("store addresses out of order");
   load_done_a:
   assert property (@(posedge ref_clk) disable iff (!reset_n || !core_supply_good)
      nv_rd_en && nv_addr == CFG_LAST_ADDR |-> ##[2:8] port_enabled)
      else $error("not running soon after load");
   no_read_run_a:
   assert property (@(posedge ref_clk) disable iff (!reset_n) port_enabled |-> !nv_rd_en)
      else $error("store read while running");
   run_fabric_a:
   assert property (@(posedge ref_clk) disable iff (!reset_n)
      $rose(port_enabled) |-> fabric_enable == nv_programmed)
      else $error("fabric enable wrong at start");
   erased_off_a:
   assert property (@(posedge ref_clk) disable iff (!reset_n)
      port_enabled && !nv_programmed |-> !fabric_enable && &pads.pull)
      else $error("erased part not held off");
   supply_loss_a:
   assert property (@(posedge ref_clk) disable iff (!reset_n)
      $fell(core_supply_good) |-> ##[1:6] (!port_enabled && !fabric_enable))
      else $error("still running after supply loss");
   port_off_a:
   assert property (@(posedge tck) disable iff (!reset_n) (!port_enabled)[*4] |-> tdo_oe_n)
      else $error("tdo driven while port off");
endmodule

bind tppc_top tppc_chk u_chk (.ref_clk, .reset_n, .core_supply_good, .nv_programmed,
   .nv_rd_en, .nv_addr, .tck, .tdo_oe_n, .pads, .core_in, .fabric_enable, .port_enabled);

/* tb/testbench.sv */
// testbench: power-up and scan scenarios for the test port top
// assumes: host model on the serial port, store model below
`timescale 1ns/1ps
module testbench;
   import tppc_pkg::*;
   localparam logic [31:0] USER_WORD = 32'hC0DE_5A17;
   localparam logic [31:0] KEEP_WORD = 32'h0000_003C;
   logic              ref_clk, reset_n, core_supply_good, nv_programmed, nv_rd_en;
   logic              tck, tms, tdi, tdo, tdo_oe_n, tdo_line, fabric_enable, port_enabled;
   logic [CFG_AW-1:0] nv_addr;
   logic [31:0]       nv_data, q;
   logic [7:0]        pad_in, core_out, core_oe, core_in;
   tppc_pads_t        pads;
   int                fails, num_checks, rd_seen;

   tppc_top u_dut (.ref_clk, .reset_n, .core_supply_good, .nv_programmed, .nv_rd_en,
      .nv_addr, .nv_data, .tck, .tms, .tdi, .tdo, .tdo_oe_n, .pad_in, .pads, .core_out,
      .core_oe, .core_in, .fabric_enable, .port_enabled);
   assign tdo_line = tdo_oe_n ? 1'b1 : tdo;
   tppc_host u_host (.tck, .tms, .tdi, .tdo(tdo_line));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // store model, answers one cycle after the read
   always @(posedge ref_clk) begin
      if (nv_rd_en) begin
         rd_seen <= rd_seen + 1;
         nv_data <= (nv_addr == CFG_USER_ADDR) ? USER_WORD :
                    (nv_addr == CFG_KEEP_ADDR) ? KEEP_WORD : {8{nv_addr}};
      end else begin
         nv_data <= ~nv_data;
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic pins(input logic [7:0] d, input logic [7:0] oe_n, input logic [7:0] p);
      check({24'h0, pads.dout}, {24'h0, d});
      check({24'h0, pads.oe_n}, {24'h0, oe_n});
      check({24'h0, pads.pull}, {24'h0, p});
   endtask
   task automatic load_ir(input logic [7:0] code);
      u_host.scan(1'b1, 8, {24'h0, code}, q);
      check(q, 32'h1);
      repeat (8) @(posedge ref_clk);
   endtask
   task automatic dr(input int n, input logic [31:0] d, input logic [31:0] exp);
      u_host.scan(1'b0, n, d, q);
      check(q, exp);
      repeat (8) @(posedge ref_clk);
   endtask

   task automatic power_up(input logic prog);
      int n;
      @(posedge ref_clk);
      reset_n <= 1'b0;
      core_supply_good <= 1'b0;
      nv_programmed <= prog;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      u_host.scan(1'b1, 8, 32'hFF, q);
      @(posedge ref_clk);
      pins(8'h00, 8'hFF, 8'hFF);
      check({31'h0, port_enabled}, 32'h0);
      rd_seen = 0;
      core_supply_good <= 1'b1;
      n = 0;
      while (port_enabled !== 1'b1 && n < 100) begin
         @(posedge ref_clk);
         n++;
      end
      check({31'h0, port_enabled}, 32'h1);
      check(rd_seen, 16);
      u_host.tap_reset();
      repeat (8) @(posedge ref_clk);
      check({31'h0, fabric_enable}, {31'h0, prog});
      if (prog) pins(8'hA5, 8'h0F, KEEP_WORD[7:0]);
      else pins(8'h00, 8'hFF, 8'hFF);
      check({24'h0, core_in}, prog ? 32'h5A : 32'h0);
      dr(32, 32'h0, ID_WORD_DEFAULT);
      $display("power-up test done, programmed %0d", prog);
   endtask

   task automatic t_codes();
      load_ir(IR_USERCODE);
      dr(32, 32'h0, USER_WORD);
      for (int i = 0; i < 2; i++) begin
         load_ir(i == 0 ? IR_BYPASS : 8'h5E);
         dr(8, 32'hB6, 32'h6C);
      end
      $display("code test done");
   endtask

   task automatic t_boundary();
      load_ir(IR_PRELOAD);
      dr(24, 32'h00C30F, 32'h5AA5F0);
      pins(8'hA5, 8'h0F, KEEP_WORD[7:0]);
      load_ir(IR_EXTEST);
      pins(8'hC3, 8'hF0, KEEP_WORD[7:0]);
      load_ir(IR_CLAMP);
      pins(8'hC3, 8'hF0, KEEP_WORD[7:0]);
      dr(8, 32'h35, 32'h6A);
      load_ir(IR_HIGHZ);
      check({24'h0, pads.oe_n}, 32'hFF);
      load_ir(IR_INTEST);
      dr(24, 32'h960000, 32'h5AA5F0);
      check({24'h0, core_in}, 32'h96);
      $display("boundary test done");
   endtask

   task automatic t_supply_loss();
      @(posedge ref_clk);
      core_supply_good <= 1'b0;
      repeat (10) @(posedge ref_clk);
      check({31'h0, port_enabled}, 32'h0);
      pins(8'h00, 8'hFF, 8'hFF);
      $display("supply loss test done");
   endtask

   task automatic report_and_stop();
      $display("checks made %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      {reset_n, core_supply_good, nv_programmed, nv_data} = '0;
      {pad_in, core_out, core_oe} = 24'h5AA5F0;
      {fails, num_checks, rd_seen} = '0;
      power_up(1'b1);
      t_codes();
      t_boundary();
      t_supply_loss();
      power_up(1'b0);
      report_and_stop();
   end
   initial begin
      #400_000;
      fails++;
      report_and_stop();
   end
endmodule
